// file: event_detector.sv
// Emulator event detector: sixteen slots combined into one condition
// How it works
// RULE_01: Sixteen independent slots, any position, all active.
// RULE_02: Fetch slot matches executed instruction address.
// RULE_03: Prefetch-only cycles never match a fetch slot.
// RULE_04: Data slot matches address or range plus qualifiers.
// RULE_05: Interrupt slot sees servicing start and end.
// RULE_06: Trigger slot matches programmed external trigger level.
// RULE_07: OR mode: any enabled slot match.
// RULE_08: Accumulated AND: all enabled slots matched once.
// RULE_09: Simultaneous AND: all enabled slots same cycle.
// RULE_10: Subroutine: chosen event inside routine address range. The code takes any enabled slot hit, with no event selection.
// RULE_11: Sequential: events in order, final step fires.
// RULE_12: State mode: programmable machine driven by slots.
// RULE_13: Slot index beyond sixteen flags error, ignored.
// RULE_14: Edits take effect only after apply.
// RULE_15: Data size qualifier for byte or word.
// RULE_16: Condition selectable for break, trace, performance.
// RULE_17: Sequence has six steps plus reset event.
// RULE_18: Three states, nine paths, plus reset event.
// RULE_19: Break issued after 0..65535 cycle delay.
// RULE_20: Reset clears matches, flags, sequence, condition.
`timescale 1ns/10ps
module event_detector
  import event_detector_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Slot editing
  input wire logic i_edit_we,
  input wire logic [4:0] i_edit_slot,
  input wire logic i_edit_en,
  input wire logic [1:0] i_edit_kind,
  input wire logic [ADDR_W-1:0] i_edit_addr_lo,
  input wire logic [ADDR_W-1:0] i_edit_addr_hi,
  input wire logic i_edit_range,
  input wire logic [1:0] i_edit_size,
  input wire logic [1:0] i_edit_dir,
  input wire logic [1:0] i_edit_irq,
  input wire logic i_edit_trig_lvl,
  input wire logic i_apply,
  // Combination settings, captured on apply
  input wire logic [2:0] i_mode,
  input wire logic [ADDR_W-1:0] i_sub_lo,
  input wire logic [ADDR_W-1:0] i_sub_hi,
  input wire logic [2:0] i_seq_len,
  input wire logic [SEQ_STEPS*SLOT_IDX_W-1:0] i_seq_slots,
  input wire logic [SLOT_IDX_W-1:0] i_seq_rst_slot,
  input wire logic [NUM_PATHS*8-1:0] i_paths,
  input wire logic [1:0] i_st_goal,
  input wire logic [SLOT_IDX_W-1:0] i_st_rst_slot,
  input wire logic i_use_brk,
  input wire logic i_use_trc,
  input wire logic i_use_perf,
  input wire logic [DELAY_W-1:0] i_brk_delay,
  // Monitored bus
  input wire logic i_exec,
  input wire logic [ADDR_W-1:0] i_exec_addr,
  input wire logic i_dacc,
  input wire logic [ADDR_W-1:0] i_dacc_addr,
  input wire logic i_dacc_word,
  input wire logic i_dacc_write,
  input wire logic i_irq_start,
  input wire logic i_irq_end,
  input wire logic i_trig_pin,
  // Results
  output logic o_edit_err,
  output logic o_cond,
  output logic o_brk_cond,
  output logic o_trc_cond,
  output logic o_perf_cond,
  output logic o_break,
  output logic [NUM_SLOTS-1:0] o_acc_flags,
  output logic [2:0] o_seq_step,
  output logic [1:0] o_st_state
);
  logic [NUM_SLOTS-1:0] hit;
  logic [NUM_SLOTS-1:0] en;
  logic [NUM_SLOTS-1:0] ld;
  logic trig_s1_r;
  logic trig_s2_r;
  logic trig_s3_r;
  logic trig_r;
  logic edit_err_r;
  comb_mode_t mode_r;
  logic [ADDR_W-1:0] sub_lo_r;
  logic [ADDR_W-1:0] sub_hi_r;
  logic [2:0] seq_len_r;
  logic [SEQ_STEPS*SLOT_IDX_W-1:0] seq_slots_r;
  logic [SLOT_IDX_W-1:0] seq_rst_r;
  logic [NUM_PATHS*8-1:0] paths_r;
  logic [1:0] st_goal_r;
  logic [SLOT_IDX_W-1:0] st_rst_r;
  logic use_brk_r;
  logic use_trc_r;
  logic use_perf_r;
  logic [DELAY_W-1:0] delay_r;
  logic [NUM_SLOTS-1:0] acc_r;
  logic [NUM_SLOTS-1:0] acc_nxt;
  logic [2:0] step_r;
  logic [2:0] step_nxt;
  logic [1:0] st_r;
  logic [1:0] st_nxt;
  logic cond_r;
  logic cond_nxt;
  brk_state_t brk_r;
  brk_state_t brk_nxt;
  logic [DELAY_W-1:0] cnt_r;
  logic [DELAY_W-1:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      trig_s1_r <= i_trig_pin;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      if (trig_s2_r == trig_s3_r) begin
        trig_r <= trig_s3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot array and edit decode
  wire edit_bad = i_edit_we && i_edit_slot[4]; // RULE_13
  wire edit_ok = i_edit_we && !i_edit_slot[4];

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : gen_slot
      assign ld[g] = edit_ok && (i_edit_slot[3:0] == SLOT_IDX_W'(g)); // RULE_01
      event_slot u_slot (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_load(ld[g]),
        .i_apply(i_apply),
        .i_en_in(i_edit_en),
        .i_kind_in(i_edit_kind),
        .i_addr_lo_in(i_edit_addr_lo),
        .i_addr_hi_in(i_edit_addr_hi),
        .i_range_in(i_edit_range),
        .i_size_in(i_edit_size),
        .i_dir_in(i_edit_dir),
        .i_irq_in(i_edit_irq),
        .i_trig_lvl_in(i_edit_trig_lvl),
        .i_exec(i_exec),
        .i_exec_addr(i_exec_addr),
        .i_dacc(i_dacc),
        .i_dacc_addr(i_dacc_addr),
        .i_dacc_word(i_dacc_word),
        .i_dacc_write(i_dacc_write),
        .i_irq_start(i_irq_start),
        .i_irq_end(i_irq_end),
        .i_trig(trig_r),
        .o_en(en[g]),
        .o_hit(hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Slots stage edits and commit them on apply
  // Combination settings are captured on apply.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edit_err_r <= 1'b0;
    end else begin
      edit_err_r <= edit_bad; // RULE_13
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_r <= MODE_OR;
      sub_lo_r <= '0;
      sub_hi_r <= '0;
      seq_len_r <= 3'h0;
      seq_slots_r <= '0;
      seq_rst_r <= '0;
      paths_r <= '0;
      st_goal_r <= 2'h0;
      st_rst_r <= '0;
      use_brk_r <= 1'b0;
      use_trc_r <= 1'b0;
      use_perf_r <= 1'b0;
      delay_r <= DELAY_RESET;
    end else if (i_apply) begin // RULE_14
      mode_r <= comb_mode_t'(i_mode);
      sub_lo_r <= i_sub_lo;
      sub_hi_r <= i_sub_hi;
      seq_len_r <= i_seq_len;
      seq_slots_r <= i_seq_slots;
      seq_rst_r <= i_seq_rst_slot;
      paths_r <= i_paths;
      st_goal_r <= i_st_goal;
      st_rst_r <= i_st_rst_slot;
      use_brk_r <= i_use_brk;
      use_trc_r <= i_use_trc;
      use_perf_r <= i_use_perf;
      delay_r <= i_brk_delay; // RULE_19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combination terms
  wire any_hit = |hit; // RULE_07
  wire sim_all = (en != '0) && ((hit & en) == en); // RULE_09
  wire [NUM_SLOTS-1:0] acc_seen = acc_r | hit;
  wire acc_all = (en != '0) && ((acc_seen & en) == en); // RULE_08
  wire in_sub = (i_exec_addr >= sub_lo_r) && (i_exec_addr <= sub_hi_r);
  wire sub_hit = any_hit && in_sub; // RULE_10
  wire [SLOT_IDX_W-1:0] step_slot = (step_r < 3'd6)
    ? seq_slots_r[step_r*SLOT_IDX_W +: SLOT_IDX_W] : '0;
  wire step_hit = hit[step_slot];
  wire last_step = (step_r + 3'd1 >= seq_len_r); // RULE_17
  wire seq_rst = hit[seq_rst_r];
  wire st_rst = hit[st_rst_r];

  // Path byte: [7] valid, [6:5] from, [4:3] to, [2:0] slot 0..7
  // Lowest numbered path wins; state 3 is never entered
  always_comb begin
    st_nxt = st_r;
    for (int p = NUM_PATHS - 1; p >= 0; p--) begin // RULE_18
      if (paths_r[p*8+7] && paths_r[p*8+5 +: 2] == st_r
          && hit[{1'b0, paths_r[p*8 +: 3]}]) begin
        st_nxt = paths_r[p*8+3 +: 2];
      end
    end
    if (st_nxt == 2'd3) begin
      st_nxt = st_r;
    end
    if (st_rst) begin
      st_nxt = 2'd0;
    end
  end

  always_comb begin
    acc_nxt = acc_r;
    step_nxt = step_r;
    cond_nxt = 1'b0;
    unique case (mode_r)
      MODE_OR: cond_nxt = any_hit; // RULE_07
      MODE_AND_ACC: begin
        cond_nxt = acc_all; // RULE_08
        acc_nxt = acc_all ? '0 : (acc_seen & en);
      end
      MODE_AND_SIM: cond_nxt = sim_all; // RULE_09
      MODE_SUBR: cond_nxt = sub_hit; // RULE_10
      MODE_SEQ: begin
        if (seq_rst) begin // RULE_17
          step_nxt = 3'd0;
        end else if (step_hit) begin // RULE_11
          if (last_step) begin
            cond_nxt = 1'b1;
            step_nxt = 3'd0;
          end else begin
            step_nxt = step_r + 3'd1;
          end
        end
      end
      MODE_STATE: cond_nxt = (st_nxt == st_goal_r) && (st_r != st_goal_r); // RULE_12
      default: cond_nxt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break delay
  always_comb begin
    brk_nxt = brk_r;
    cnt_nxt = cnt_r;
    unique case (brk_r)
      BRK_IDLE: begin
        if (cond_r && use_brk_r) begin
          cnt_nxt = delay_r;
          brk_nxt = (delay_r == DELAY_RESET) ? BRK_FIRE : BRK_WAIT;
        end
      end
      BRK_WAIT: begin
        cnt_nxt = cnt_r - 16'h0001; // RULE_19
        if (cnt_r == 16'h0001) begin
          brk_nxt = BRK_FIRE;
        end
      end
      BRK_FIRE: brk_nxt = BRK_IDLE;
      default: brk_nxt = BRK_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin // RULE_20
      acc_r <= '0;
      step_r <= 3'd0;
      st_r <= 2'd0;
      cond_r <= 1'b0;
      brk_r <= BRK_IDLE;
      cnt_r <= DELAY_RESET;
    end else if (i_apply) begin
      acc_r <= '0;
      step_r <= 3'd0;
      st_r <= 2'd0;
      cond_r <= 1'b0;
      brk_r <= BRK_IDLE;
      cnt_r <= DELAY_RESET;
    end else begin
      acc_r <= acc_nxt;
      step_r <= step_nxt;
      st_r <= st_nxt;
      cond_r <= cond_nxt;
      brk_r <= brk_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_edit_err = edit_err_r;
  assign o_cond = cond_r;
  assign o_brk_cond = cond_r && use_brk_r; // RULE_16
  assign o_trc_cond = cond_r && use_trc_r; // RULE_16
  assign o_perf_cond = cond_r && use_perf_r; // RULE_16
  assign o_break = (brk_r == BRK_FIRE);
  assign o_acc_flags = acc_r;
  assign o_seq_step = step_r;
  assign o_st_state = st_r;
endmodule

// file: event_detector_pkg.sv
// Constants and types shared by the emulator event detector
package event_detector_pkg;
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_IDX_W = 4;
  localparam int ADDR_W = 24;
  localparam int SEQ_STEPS = 6;
  localparam int NUM_STATES = 3;
  localparam int NUM_PATHS = 9;
  localparam int DELAY_W = 16;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam int CLK_MHZ = 250;
  localparam logic [15:0] ALL_ONES16 = 16'hFFFF;

  typedef enum logic [1:0] {
    KIND_FETCH = 2'b00,
    KIND_DATA = 2'b01,
    KIND_IRQ = 2'b10,
    KIND_TRIG = 2'b11
  } slot_kind_t;

  typedef enum logic [2:0] {
    MODE_OR = 3'b000,
    MODE_AND_ACC = 3'b001,
    MODE_AND_SIM = 3'b010,
    MODE_SUBR = 3'b011,
    MODE_SEQ = 3'b100,
    MODE_STATE = 3'b101
  } comb_mode_t;

  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_WAIT = 2'b01,
    BRK_FIRE = 2'b10
  } brk_state_t;

  // Size qualifier: bit0 allows byte access, bit1 allows word access
  localparam int SIZE_BYTE_BIT = 0;
  localparam int SIZE_WORD_BIT = 1;
  // Direction qualifier: bit0 allows read, bit1 allows write
  localparam int DIR_READ_BIT = 0;
  localparam int DIR_WRITE_BIT = 1;
  // Interrupt qualifier: bit0 start of servicing, bit1 end of servicing
  localparam int IRQ_START_BIT = 0;
  localparam int IRQ_END_BIT = 1;
endpackage

// file: event_slot.sv
// One event slot matching a bus cycle against its applied settings
`timescale 1ns/10ps
module event_slot
  import event_detector_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_load,
  input wire logic i_apply,
  input wire logic i_en_in,
  input wire logic [1:0] i_kind_in,
  input wire logic [ADDR_W-1:0] i_addr_lo_in,
  input wire logic [ADDR_W-1:0] i_addr_hi_in,
  input wire logic i_range_in,
  input wire logic [1:0] i_size_in,
  input wire logic [1:0] i_dir_in,
  input wire logic [1:0] i_irq_in,
  input wire logic i_trig_lvl_in,
  input wire logic i_exec,
  input wire logic [ADDR_W-1:0] i_exec_addr,
  input wire logic i_dacc,
  input wire logic [ADDR_W-1:0] i_dacc_addr,
  input wire logic i_dacc_word,
  input wire logic i_dacc_write,
  input wire logic i_irq_start,
  input wire logic i_irq_end,
  input wire logic i_trig,
  output logic o_en,
  output logic o_hit
);
  logic en_r;
  logic [1:0] kind_r;
  logic [ADDR_W-1:0] lo_r;
  logic [ADDR_W-1:0] hi_r;
  logic range_r;
  logic [1:0] size_r;
  logic [1:0] dir_r;
  logic [1:0] irq_r;
  logic trig_r;
  logic en_s_r;
  logic [1:0] kind_s_r;
  logic [ADDR_W-1:0] lo_s_r;
  logic [ADDR_W-1:0] hi_s_r;
  logic range_s_r;
  logic [1:0] size_s_r;
  logic [1:0] dir_s_r;
  logic [1:0] irq_s_r;
  logic trig_s_r;

  ////////////////////////////////////////////////////////////////////////////
  // Staged settings, written by the edit strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_s_r <= 1'b0;
      kind_s_r <= 2'b00;
      lo_s_r <= '0;
      hi_s_r <= '0;
      range_s_r <= 1'b0;
      size_s_r <= 2'b00;
      dir_s_r <= 2'b00;
      irq_s_r <= 2'b00;
      trig_s_r <= 1'b0;
    end else if (i_load) begin // RULE_14
      en_s_r <= i_en_in;
      kind_s_r <= i_kind_in;
      lo_s_r <= i_addr_lo_in;
      hi_s_r <= i_addr_hi_in;
      range_s_r <= i_range_in;
      size_s_r <= i_size_in;
      dir_s_r <= i_dir_in;
      irq_s_r <= i_irq_in;
      trig_s_r <= i_trig_lvl_in;
    end
  end

  // Applied settings, updated only on apply
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_r <= 1'b0;
      kind_r <= 2'b00;
      lo_r <= '0;
      hi_r <= '0;
      range_r <= 1'b0;
      size_r <= 2'b00;
      dir_r <= 2'b00;
      irq_r <= 2'b00;
      trig_r <= 1'b0;
    end else if (i_apply) begin // RULE_14
      en_r <= en_s_r;
      kind_r <= kind_s_r;
      lo_r <= lo_s_r;
      hi_r <= hi_s_r;
      range_r <= range_s_r;
      size_r <= size_s_r;
      dir_r <= dir_s_r;
      irq_r <= irq_s_r;
      trig_r <= trig_s_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match logic
  wire fetch_hit = i_exec && (i_exec_addr == lo_r); // RULE_02 RULE_03
  wire addr_ok = range_r ? (i_dacc_addr >= lo_r && i_dacc_addr <= hi_r)
                         : (i_dacc_addr == lo_r);
  wire size_ok = i_dacc_word ? size_r[SIZE_WORD_BIT] : size_r[SIZE_BYTE_BIT]; // RULE_15
  wire dir_ok = i_dacc_write ? dir_r[DIR_WRITE_BIT] : dir_r[DIR_READ_BIT];
  wire data_hit = i_dacc && addr_ok && size_ok && dir_ok; // RULE_04
  wire irq_hit = (i_irq_start && irq_r[IRQ_START_BIT])
              || (i_irq_end && irq_r[IRQ_END_BIT]); // RULE_05
  wire trig_hit = (i_trig == trig_r); // RULE_06
  wire any_hit = (kind_r == KIND_FETCH) ? fetch_hit
               : (kind_r == KIND_DATA) ? data_hit
               : (kind_r == KIND_IRQ) ? irq_hit
               : trig_hit;

  assign o_en = en_r;
  assign o_hit = en_r && any_hit;
endmodule

// file: event_detector_sva.sv
// Assertion checker on the event detector ports
`timescale 1ns/10ps
module event_detector_sva
  import event_detector_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_edit_we,
  input wire logic [4:0] i_edit_slot,
  input wire logic i_apply,
  input wire logic [DELAY_W-1:0] i_brk_delay,
  input wire logic o_edit_err,
  input wire logic o_cond,
  input wire logic o_brk_cond,
  input wire logic o_trc_cond,
  input wire logic o_perf_cond,
  input wire logic o_break,
  input wire logic [NUM_SLOTS-1:0] o_acc_flags,
  input wire logic [1:0] o_st_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire bad_edit = i_edit_we && i_edit_slot[4];
  sequence brk_now;
    o_brk_cond && i_brk_delay == 16'h0 && $stable(i_brk_delay);
  endsequence
  sequence quiet;
    !o_cond && !o_break && o_acc_flags == 16'h0 && o_st_state == 2'h0;
  endsequence
  ////////////////////////////////////////////////////////////////
  a_err_flag: assert property (bad_edit |=> o_edit_err)
    else $error("edit error flag missing");
  a_err_quiet: assert property (!bad_edit |=> !o_edit_err)
    else $error("edit error flag without bad edit");
  a_brk_route: assert property (o_brk_cond |-> o_cond)
    else $error("break condition without condition");
  a_trc_route: assert property (o_trc_cond |-> o_cond)
    else $error("trace condition without condition");
  a_perf_route: assert property (o_perf_cond |-> o_cond)
    else $error("performance condition without condition");
  a_brk_zero: assert property (brk_now |=> o_break)
    else $error("zero delay break late");
  a_apply_drop: assert property (i_apply |=> !o_cond)
    else $error("condition from apply cycle");
  a_state_legal: assert property (o_st_state != 2'h3)
    else $error("illegal state reached");
  a_reset_clear: assert property ($rose(i_rst_b) |-> quiet)
    else $error("state not cleared by reset");
endmodule
bind event_detector event_detector_sva chk_u (.*);

// file: cpu_bus_model.sv
// Behavioural model of the monitored CPU bus
`timescale 1ns/10ps
module cpu_bus_model
  import event_detector_pkg::*;
(
  input wire logic i_clk,
  output logic o_exec,
  output logic [ADDR_W-1:0] o_exec_addr,
  output logic o_dacc,
  output logic [ADDR_W-1:0] o_dacc_addr,
  output logic o_dacc_word,
  output logic o_dacc_write,
  output logic o_irq_start,
  output logic o_irq_end,
  output logic o_trig_pin
);
  initial begin
    {o_exec, o_dacc, o_dacc_word, o_dacc_write, o_irq_start, o_irq_end, o_trig_pin} = 7'h0;
    {o_exec_addr, o_dacc_addr} = 48'h0;
  end
  ////////////////////////////////////////////////////////////////
  // Executed cycle when run is high, prefetch-only cycle otherwise
  task automatic fetch(input logic [ADDR_W-1:0] a, input logic run);
    @(posedge i_clk);
    o_exec <= run;
    o_exec_addr <= a;
    @(posedge i_clk);
    o_exec <= 1'b0;
    o_exec_addr <= ~a;
    #1;
  endtask
  task automatic data(input logic [ADDR_W-1:0] a, input logic wd, input logic wr);
    @(posedge i_clk);
    o_dacc <= 1'b1;
    o_dacc_addr <= a;
    o_dacc_word <= wd;
    o_dacc_write <= wr;
    @(posedge i_clk);
    o_dacc <= 1'b0;
    o_dacc_addr <= ~a;
    #1;
  endtask
  // One-cycle interrupt service start or end
  task automatic irq(input logic s, input logic e);
    @(posedge i_clk);
    o_irq_start <= s;
    o_irq_end <= e;
    @(posedge i_clk);
    o_irq_start <= 1'b0;
    o_irq_end <= 1'b0;
    #1;
  endtask
  // Trigger level held until the synchroniser has settled
  task automatic trig(input logic lvl);
    @(posedge i_clk);
    o_trig_pin <= lvl;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
endmodule

// file: event_detector_tb.sv
// Self-checking testbench for the emulator event detector
`timescale 1ns/10ps
module event_detector_tb
  import event_detector_pkg::*;
;
  logic i_clk, i_rst_b, i_edit_we, i_edit_en, i_edit_range, i_edit_trig_lvl, i_apply;
  logic i_use_brk, i_use_trc, i_use_perf, o_edit_err, o_cond, o_brk_cond, o_trc_cond;
  logic o_perf_cond, o_break, i_exec, i_dacc, i_dacc_word, i_dacc_write, i_trig_pin;
  logic i_irq_start, i_irq_end;
  logic [4:0] i_edit_slot;
  logic [1:0] i_edit_kind, i_edit_size, i_edit_dir, i_edit_irq, i_st_goal, o_st_state;
  logic [2:0] i_mode, i_seq_len, o_seq_step;
  logic [ADDR_W-1:0] i_edit_addr_lo, i_edit_addr_hi, i_sub_lo, i_sub_hi, i_exec_addr;
  logic [ADDR_W-1:0] i_dacc_addr;
  logic [SEQ_STEPS*SLOT_IDX_W-1:0] i_seq_slots;
  logic [SLOT_IDX_W-1:0] i_seq_rst_slot, i_st_rst_slot;
  logic [NUM_PATHS*8-1:0] i_paths;
  logic [DELAY_W-1:0] i_brk_delay;
  logic [NUM_SLOTS-1:0] o_acc_flags;
  int n_errors;
  int compares;
  event_detector dut_u (.*);
  cpu_bus_model bus_u (.i_clk(i_clk), .o_exec(i_exec), .o_exec_addr(i_exec_addr),
    .o_dacc(i_dacc), .o_dacc_addr(i_dacc_addr), .o_dacc_word(i_dacc_word),
    .o_dacc_write(i_dacc_write), .o_irq_start(i_irq_start), .o_irq_end(i_irq_end),
    .o_trig_pin(i_trig_pin));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string s, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Slot edit; q packs enable, range, size, direction, interrupt, level
  task automatic slot(input logic [4:0] n, input logic [1:0] k, input logic [23:0] lo,
      input logic [23:0] hi, input logic [8:0] q);
    @(posedge i_clk);
    i_edit_slot <= n;
    i_edit_kind <= k;
    i_edit_addr_lo <= lo;
    i_edit_addr_hi <= hi;
    {i_edit_en, i_edit_range, i_edit_size, i_edit_dir, i_edit_irq, i_edit_trig_lvl} <= q;
    i_edit_we <= 1'b1;
    @(posedge i_clk);
    i_edit_we <= 1'b0;
    #1;
  endtask
  task automatic apply(input logic [2:0] m, input logic [2:0] u, input logic [15:0] d);
    @(posedge i_clk);
    i_mode <= m;
    {i_use_brk, i_use_trc, i_use_perf} <= u;
    i_brk_delay <= d;
    i_apply <= 1'b1;
    @(posedge i_clk);
    i_apply <= 1'b0;
  endtask
  task automatic fc(input logic [23:0] a, input logic e);
    bus_u.fetch(a, 1'b1);
    check("cond", o_cond, e);
  endtask
  task automatic walk(input logic [23:0] a, input logic [5:0] e);
    bus_u.fetch(a, 1'b1);
    check("walk", {o_cond, o_seq_step, o_st_state}, e);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_or();
    int n;
    slot(5'h00, KIND_FETCH, 24'h001000, 24'h0, 9'h100);
    slot(5'h0F, KIND_FETCH, 24'h002000, 24'h0, 9'h100);
    apply(MODE_OR, 3'b101, 16'h0);
    bus_u.fetch(24'h001000, 1'b0);
    check("prefetch", o_cond, 1'b0);
    fc(24'h001004, 1'b0);
    fc(24'h002000, 1'b1);
    fc(24'h001000, 1'b1);
    check("route", {o_brk_cond, o_trc_cond, o_perf_cond}, 24'h5);
    @(posedge i_clk);
    #1;
    check("break", o_break, 1'b1);
    slot(5'h10, KIND_FETCH, 24'h003000, 24'h0, 9'h100);
    check("edit err", o_edit_err, 1'b1);
    fc(24'h003000, 1'b0);
    apply(MODE_OR, 3'b100, 16'h3);
    bus_u.fetch(24'h001000, 1'b1);
    n = 0;
    while (o_break !== 1'b1 && n < 9) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("delay", 24'(n), 24'h4);
    $display("or test done");
  endtask
  task automatic t_and();
    for (int k = 0; k < NUM_SLOTS; k++) begin
      slot(5'(k), KIND_FETCH, 24'h0, 24'h0, 9'h000);
    end
    slot(5'h00, KIND_FETCH, 24'h001000, 24'h0, 9'h100);
    slot(5'h01, KIND_DATA, 24'h000500, 24'h0005FF, 9'h1B0);
    apply(MODE_OR, 3'b000, 16'h0);
    bus_u.data(24'h000600, 1'b0, 1'b1);
    check("above", o_cond, 1'b0);
    bus_u.data(24'h000500, 1'b1, 1'b1);
    check("word", o_cond, 1'b0);
    bus_u.data(24'h0005FF, 1'b0, 1'b0);
    check("read", o_cond, 1'b0);
    @(posedge i_clk);
    i_mode <= MODE_AND_ACC;
    fc(24'h001000, 1'b1);
    apply(MODE_AND_ACC, 3'b000, 16'h0);
    fc(24'h001000, 1'b0);
    check("flags", o_acc_flags, 24'h1);
    bus_u.data(24'h0005FF, 1'b0, 1'b1);
    check("acc", o_cond, 1'b1);
    slot(5'h01, KIND_TRIG, 24'h0, 24'h0, 9'h101);
    apply(MODE_AND_SIM, 3'b000, 16'h0);
    fc(24'h001000, 1'b0);
    bus_u.trig(1'b1);
    fc(24'h001000, 1'b1);
    bus_u.trig(1'b0);
    $display("and test done");
  endtask
  task automatic t_seq();
    slot(5'h01, KIND_FETCH, 24'h001004, 24'h0, 9'h100);
    slot(5'h02, KIND_FETCH, 24'h001008, 24'h0, 9'h100);
    @(posedge i_clk);
    i_seq_len <= 3'h2;
    i_seq_slots <= 24'h000010;
    i_seq_rst_slot <= 4'h2;
    i_paths <= {56'h0, 8'hB1, 8'h88};
    i_st_goal <= 2'h2;
    i_st_rst_slot <= 4'h2;
    i_sub_lo <= 24'h001000;
    i_sub_hi <= 24'h001004;
    apply(MODE_SEQ, 3'b000, 16'h0);
    walk(24'h001004, 6'h00);
    walk(24'h001000, 6'h05);
    walk(24'h001008, 6'h00);
    walk(24'h001000, 6'h05);
    walk(24'h001004, 6'h22);
    apply(MODE_STATE, 3'b000, 16'h0);
    walk(24'h001004, 6'h00);
    walk(24'h001000, 6'h01);
    walk(24'h001008, 6'h00);
    walk(24'h001000, 6'h01);
    walk(24'h001004, 6'h22);
    apply(MODE_SUBR, 3'b000, 16'h0);
    walk(24'h001008, 6'h00);
    walk(24'h001004, 6'h20);
    apply(MODE_OR, 3'b000, 16'h0);
    slot(5'h03, KIND_IRQ, 24'h0, 24'h0, 9'h104);
    bus_u.irq(1'b0, 1'b1);
    check("staged", o_cond, 1'b0);
    apply(MODE_OR, 3'b000, 16'h0);
    bus_u.irq(1'b1, 1'b0);
    check("irq start", o_cond, 1'b0);
    bus_u.irq(1'b0, 1'b1);
    check("irq end", o_cond, 1'b1);
    slot(5'h04, KIND_IRQ, 24'h0, 24'h0, 9'h102);
    apply(MODE_OR, 3'b000, 16'h0);
    bus_u.irq(1'b1, 1'b0);
    check("irq start", o_cond, 1'b1);
    $display("sequence test done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    n_errors = 0;
    compares = 0;
    i_rst_b = 1'b0;
    {i_edit_we, i_edit_en, i_edit_range, i_edit_trig_lvl, i_apply} = 5'h0;
    {i_use_brk, i_use_trc, i_use_perf, i_edit_slot, i_edit_kind} = 10'h0;
    {i_edit_size, i_edit_dir, i_edit_irq, i_st_goal, i_mode, i_seq_len} = 14'h0;
    {i_edit_addr_lo, i_edit_addr_hi, i_sub_lo, i_sub_hi} = 96'h0;
    {i_seq_slots, i_seq_rst_slot, i_st_rst_slot, i_paths, i_brk_delay} = 120'h0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1;
    check("reset", {o_cond, o_break, o_acc_flags}, 24'h0);
    check("reset", {o_edit_err, o_seq_step, o_st_state}, 24'h0);
    t_or();
    t_and();
    t_seq();
    give_verdict();
  end
endmodule
